// ---- rtl/phy_evs_cfg.svh ----
/*
 * Register offsets, bit positions, reset values and frame constants for the
 * event latch and link state report registers.
 * Assumes a 5-bit register address on the management serial link.
 */
`ifndef PHY_EVS_CFG_SVH
`define PHY_EVS_CFG_SVH

// Register addresses on the management link
`define EVS_REG_MASK    5'h18
`define EVS_REG_EVT     5'h19
`define EVS_REG_STS     5'h1A

// Reset values
`define EVS_EVT_RST     16'h0000
`define EVS_MASK_RST    16'h0000
`define EVS_STS_RST     16'h0700

// Bit positions
`define EVS_BIT_PEND    0
`define EVS_BIT_DIAG    10
`define EVS_BIT_FIRST   1
`define EVS_BIT_LAST    10
`define EVS_BIT_STANDBY 15
`define EVS_BIT_LINK    6
`define EVS_BIT_SPD_LO  8
`define EVS_RSV_W       5

// Management frame fields
`define EVS_PREAMBLE    6'd32
`define EVS_OP_READ     2'b10
`define EVS_OP_WRITE    2'b01
`define EVS_HDR_LAST    4'd11
`define EVS_DATA_LAST   4'd15

`endif

// ---- rtl/phy_evs_pkg.sv ----
/*
 * Types shared by the event and status register bank.
 * Assumes the constants header is included where offsets are needed.
 */
package phy_evs_pkg;

	typedef enum logic [2:0] {
		ST_HUNT  = 3'b000,
		ST_IDLE  = 3'b001,
		ST_START = 3'b010,
		ST_HDR   = 3'b011,
		ST_TURN  = 3'b100,
		ST_DATA  = 3'b101
	} mgmt_state_t;

	// Live link state, packed in status register order, bits 14..0
	typedef struct packed {
		logic       an_fault_ms;
		logic       an_fault_pd;
		logic       an_done;
		logic       crossed_pair_config;
		logic       pol_normal;
		logic [1:0] speed;
		logic       full_duplex;
		logic       link_up;
		logic       tx_act;
		logic       rx_act;
		logic       collision;
		logic       an_both;
		logic       partner_pause;
		logic       partner_sym;
	} live_status_t;

	// Event pulses from the transceiver core; sync loss is made in the register block
	typedef struct packed {
		logic diag_run_done;
		logic an_change;
		logic crc_err;
		logic next_page;
		logic err_cnt_full;
		logic fifo_err;
		logic rx_change;
		logic link_change;
		logic downshift;
	} ext_event_t;

	typedef struct packed {
		logic [1:0] op;
		logic [4:0] phy;
		logic [4:0] reg_a;
	} mgmt_hdr_t;

endpackage

// ---- rtl/event_latch_bit.sv ----
/*
 * One latched-high event bit: set by its source, cleared by a read strobe.
 * Assumes the read strobe is a one-cycle pulse from the frame engine.
 */
`timescale 1ns/100ps
module event_latch_bit (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	// Source and clear
	input  wire logic set_in,
	input  wire logic clr_in,
	// Latched state
	output logic      bit_out
);
	logic bit_r;
	logic bit_nxt;

	// Set wins over the read clear, so an event in the clear cycle stays
	assign bit_nxt = set_in | (bit_r & ~clr_in);
	assign bit_out = bit_r;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bit_r <= 1'b0;
		end else begin
			bit_r <= bit_nxt;
		end
	end

	a_set_latches: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		set_in |=> bit_r ##1 (bit_r || $past(clr_in))) else $error("event bit not latched");
	a_idle_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(!set_in && !bit_r) |=> !bit_r) else $error("event bit set without cause");
	a_read_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(clr_in && !set_in) |=> !bit_r) else $error("event bit survived read");
endmodule

// ---- rtl/ones_run_counter.sv ----
/*
 * Counts consecutive one bits on the management data line, saturating at
 * the preamble length. Assumes step_in marks one sampling edge per bit.
 */
`timescale 1ns/100ps
module ones_run_counter #(
	parameter int unsigned WIDTH = 6
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	// Sampled bit
	input  wire logic step_in,
	input  wire logic bit_in,
	// Full preamble seen
	output logic      full_out
);
	`include "phy_evs_cfg.svh"

	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cnt_nxt;
	logic             at_top;

	assign at_top   = (cnt_r == WIDTH'(`EVS_PREAMBLE));
	assign cnt_nxt  = !step_in ? cnt_r :
	                  !bit_in  ? '0 :
	                  at_top   ? cnt_r : cnt_r + WIDTH'(1);
	assign full_out = at_top;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	a_run_breaks: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(step_in && !bit_in) |=> (cnt_r == '0)) else $error("run not reset by zero");
endmodule

// ---- rtl/phy_event_and_status_regs.sv ----
/*
 * Event latch and link state report registers of a gigabit transceiver,
 * served over the management serial link (clock and bidirectional data).
 * Assumes mdc_in and mdio_in are already synchronous to clk_in and that
 * clk_in runs well above four times the management clock.
 */
`timescale 1ns/100ps
// What this block does
// - Latch diagnostic run completion into bit 10
// - Bits 9..1 latch their events high
// - Event bits zero until event, zero reset
// - Pending set only by unmasked latched event
// - Pending reads one while unmasked event pending
// - Resync once a full preamble is seen
// - Bit 15 shows standby, resets zero
// - Standby when TDR mode and link down
// - Soft reset or power down drops link
// - Bits 14:13 report negotiation fault code
// - Bit 12 shows negotiation complete
// - Bit 11 shows crossed pair configuration
// - Bit 10 polarity normal, resets one
// - Bits 9:8 speed code, resets 11
// - Bit 7 duplex, bit 6 link up
// - Bits 5:3 live transmit, receive, collision
// - Bit 2 both ends negotiate
// - Bits 1:0 partner pause and symmetry
// - Mask bits enable matching events
// - Interrupt pin low when pending and enabled
module phy_event_and_status_regs
	import phy_evs_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         sys_rst_in,
	// Management serial link
	input  wire logic         mdc_in,
	input  wire logic         mdio_in,
	output logic              mdio_out,
	output logic              mdio_oe_out,
	input  wire logic [4:0]   phy_addr_in,
	// Control bits held in other registers
	input  wire logic         frame_preamble_skip_in,
	input  wire logic         tdr_mode_in,
	input  wire logic         soft_reset_in,
	input  wire logic         soft_power_down_in,
	// Transceiver core state
	input  wire live_status_t live_in,
	input  wire ext_event_t   events_in,
	// Outputs
	output logic              mgmt_irq_out_n,
	output logic              link_drop_out,
	output logic              in_sync_out
);
	`include "phy_evs_cfg.svh"

	localparam int unsigned NEV = `EVS_BIT_LAST;

	mgmt_state_t state_r;
	mgmt_state_t state_nxt;
	logic [3:0]  cnt_r;
	logic [3:0]  cnt_nxt;
	logic [10:0] hdr_r;
	logic [10:0] hdr_nxt;
	logic [15:0] data_r;
	logic [15:0] data_nxt;
	logic        rd_r;
	logic        rd_nxt;
	logic        mine_r;
	logic        mine_nxt;
	logic        mdc_q_r;
	logic        out_nxt;
	logic        oe_nxt;
	logic        sync_lost_nxt;
	logic        rd_clr_nxt;
	logic        rd_clr_r;
	logic        sync_lost_r;
	logic        wr_mask_nxt;
	logic [15:0] mask_r;
	logic [15:0] sts_r;
	logic [NEV:0] lat_w;

	// Bit sampling on the management clock rising edge
	logic        rise_w;
	logic        bit_w;
	logic        pre_full_w;
	mgmt_hdr_t   hdr_w;
	logic        op_ok_w;
	logic        op_rd_w;
	logic        addr_hit_w;
	logic        start_ok_w;

	assign rise_w     = mdc_in & ~mdc_q_r;
	assign bit_w      = mdio_in;
	assign hdr_w      = {hdr_r, bit_w};
	assign op_rd_w    = (hdr_w.op == `EVS_OP_READ);
	assign op_ok_w    = op_rd_w || (hdr_w.op == `EVS_OP_WRITE);
	assign addr_hit_w = (hdr_w.phy == phy_addr_in);
	// Without suppression every frame must carry a full preamble
	assign start_ok_w = !bit_w && (frame_preamble_skip_in || pre_full_w);

	ones_run_counter #(
		.WIDTH (6)
	) u_pre (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.step_in    (rise_w),
		.bit_in     (bit_w),
		.full_out   (pre_full_w)
	);

	// Register read mux; reserved event bits are constant zero
	logic [15:0] evt_word_w;
	logic [15:0] rd_word_w;

	assign evt_word_w = {`EVS_RSV_W'(0), lat_w};
	assign rd_word_w  = (hdr_w.reg_a == `EVS_REG_EVT)  ? evt_word_w :
	                    (hdr_w.reg_a == `EVS_REG_STS)  ? sts_r :
	                    (hdr_w.reg_a == `EVS_REG_MASK) ? mask_r : 16'h0000;

	always_comb begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r;
		hdr_nxt       = hdr_r;
		data_nxt      = data_r;
		rd_nxt        = rd_r;
		mine_nxt      = mine_r;
		out_nxt       = mdio_out;
		oe_nxt        = mdio_oe_out;
		sync_lost_nxt = 1'b0;
		rd_clr_nxt    = 1'b0;
		wr_mask_nxt   = 1'b0;
		if (rise_w) begin
			unique case (state_r)
				ST_HUNT: begin
					// Lost sync: only a full preamble lets a frame be accepted
					if (pre_full_w) begin
						state_nxt = bit_w ? ST_IDLE : ST_START;
					end
				end
				ST_IDLE: begin
					if (start_ok_w) begin
						state_nxt = ST_START;
					end
				end
				ST_START: begin
					if (bit_w) begin
						state_nxt = ST_HDR;
						cnt_nxt   = 4'h0;
					end else if (frame_preamble_skip_in) begin
						state_nxt     = ST_HUNT;
						sync_lost_nxt = 1'b1;
					end else begin
						state_nxt = ST_IDLE;
					end
				end
				ST_HDR: begin
					hdr_nxt = hdr_w[10:0];
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r == `EVS_HDR_LAST) begin
						cnt_nxt = 4'h0;
						if (!op_ok_w) begin
							state_nxt     = frame_preamble_skip_in ? ST_HUNT : ST_IDLE;
							sync_lost_nxt = frame_preamble_skip_in;
						end else begin
							state_nxt = ST_TURN;
							rd_nxt    = op_rd_w;
							mine_nxt  = addr_hit_w;
							if (op_rd_w && addr_hit_w) begin
								// Snapshot now, clear one cycle later via rd_clr_r; an event latched in between is lost
								data_nxt   = rd_word_w;
								rd_clr_nxt = (hdr_w.reg_a == `EVS_REG_EVT);
							end
						end
					end
				end
				ST_TURN: begin
					cnt_nxt = 4'h1;
					if (rd_r && mine_r) begin
						oe_nxt  = 1'b1;
						out_nxt = (cnt_r == 4'h0) ? 1'b0 : data_r[15];
					end
					if (cnt_r != 4'h0) begin
						state_nxt = ST_DATA;
						cnt_nxt   = 4'h0;
						if (rd_r) begin
							data_nxt = {data_r[14:0], 1'b0};
						end
					end
				end
				ST_DATA: begin
					cnt_nxt = cnt_r + 4'h1;
					if (rd_r) begin
						out_nxt  = data_r[15];
						data_nxt = {data_r[14:0], 1'b0};
					end else begin
						data_nxt = {data_r[14:0], bit_w};
					end
					if (cnt_r == `EVS_DATA_LAST) begin
						state_nxt   = ST_IDLE;
						oe_nxt      = 1'b0;
						out_nxt     = 1'b0;
						// Only the mask is writable; event and status ignore writes
						wr_mask_nxt = !rd_r && mine_r
						              && (hdr_r[4:0] == `EVS_REG_MASK);
					end
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_r     <= ST_IDLE;
			cnt_r       <= 4'h0;
			hdr_r       <= 11'h000;
			data_r      <= 16'h0000;
			rd_r        <= 1'b0;
			mine_r      <= 1'b0;
			mdc_q_r     <= 1'b0;
			mdio_out    <= 1'b0;
			mdio_oe_out <= 1'b0;
			rd_clr_r    <= 1'b0;
			sync_lost_r <= 1'b0;
			in_sync_out <= 1'b1;
		end else begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			hdr_r       <= hdr_nxt;
			data_r      <= data_nxt;
			rd_r        <= rd_nxt;
			mine_r      <= mine_nxt;
			mdc_q_r     <= mdc_in;
			mdio_out    <= out_nxt;
			mdio_oe_out <= oe_nxt;
			rd_clr_r    <= rd_clr_nxt;
			sync_lost_r <= sync_lost_nxt;
			in_sync_out <= (state_nxt != ST_HUNT);
		end
	end

	// Mask register: one enable per event, bit 0 enables the pin
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mask_r <= `EVS_MASK_RST;
		end else if (wr_mask_nxt) begin
			mask_r <= {`EVS_RSV_W'(0), data_nxt[NEV:0]};
		end
	end

	// Event latches, bits 10..1
	logic [NEV:1] ev_w;
	assign ev_w = {events_in.diag_run_done, sync_lost_r, events_in.an_change,
	               events_in.crc_err, events_in.next_page, events_in.err_cnt_full,
	               events_in.fifo_err, events_in.rx_change, events_in.link_change,
	               events_in.downshift};

	for (genvar i = `EVS_BIT_FIRST; i <= NEV; i++) begin : g_evt
		event_latch_bit u_bit (
			.clk_in     (clk_in),
			.sys_rst_in (sys_rst_in),
			.set_in     (ev_w[i]),
			.clr_in     (rd_clr_r),
			.bit_out    (lat_w[i])
		);
	end

	// Pending is latched high; a read keeps it only for latches that survive
	logic pend_src_w;
	logic pend_set_w;
	assign pend_src_w = |(lat_w[NEV:1] & mask_r[NEV:1]);
	assign pend_set_w = pend_src_w && (!rd_clr_r || |(ev_w & mask_r[NEV:1]));

	event_latch_bit u_pend (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.set_in     (pend_set_w),
		.clr_in     (rd_clr_r),
		.bit_out    (lat_w[`EVS_BIT_PEND])
	);

	// Status register and link drop
	logic link_eff_w;
	logic standby_w;
	logic [15:0] sts_nxt;

	assign link_eff_w = live_in.link_up && !link_drop_out;
	assign standby_w  = tdr_mode_in && !link_eff_w;
	assign sts_nxt    = {standby_w,
	                     live_in.an_fault_ms, live_in.an_fault_pd && !live_in.an_fault_ms,
	                     live_in.an_done, live_in.crossed_pair_config,
	                     live_in.pol_normal, live_in.speed, live_in.full_duplex,
	                     link_eff_w, live_in.tx_act, live_in.rx_act,
	                     live_in.collision, live_in.an_both,
	                     live_in.partner_pause, live_in.partner_sym};

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sts_r          <= `EVS_STS_RST;
			link_drop_out  <= 1'b0;
			mgmt_irq_out_n <= 1'b1;
		end else begin
			sts_r          <= sts_nxt;
			link_drop_out  <= soft_reset_in || soft_power_down_in;
			mgmt_irq_out_n <= !(lat_w[`EVS_BIT_PEND] && mask_r[`EVS_BIT_PEND]);
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_bad_start;
		rise_w && state_r == ST_START && !bit_w && frame_preamble_skip_in;
	endsequence
	sequence s_evt_read;
		rd_clr_r && !ev_w[`EVS_BIT_DIAG];
	endsequence

	a_diag_latch: assert property (ev_w[`EVS_BIT_DIAG] |=> lat_w[`EVS_BIT_DIAG])
		else $error("diagnostic completion not latched");
	a_pend_cause: assert property ($rose(lat_w[0]) |-> $past(pend_src_w))
		else $error("pending set without unmasked event");
	a_pend_holds: assert property ((pend_src_w && !rd_clr_r) |=> lat_w[0])
		else $error("pending dropped while event unmasked");
	a_sync_loss: assert property (s_bad_start |=> (sync_lost_r && !in_sync_out))
		else $error("sync loss not reported");
	a_hunt_waits: assert property ((state_r == ST_HUNT && !pre_full_w) |=> state_r != ST_START)
		else $error("frame accepted before preamble");
	a_standby_bit: assert property (sts_r[`EVS_BIT_STANDBY] == $past(standby_w))
		else $error("standby bit wrong");
	a_link_drop: assert property (soft_reset_in |=> ##1 !sts_r[`EVS_BIT_LINK])
		else $error("link not dropped on soft reset");
	a_status_map: assert property (sts_r[14:0] == $past(sts_nxt[14:0]))
		else $error("status bits not tracking sources");
	a_fault_code: assert property (sts_r[14:13] != 2'b11)
		else $error("illegal fault code");
	a_irq_pin: assert property (mgmt_irq_out_n == !$past(lat_w[0] && mask_r[0]))
		else $error("interrupt pin mismatch");
	a_read_clear: assert property (s_evt_read |=> !lat_w[`EVS_BIT_DIAG])
		else $error("diagnostic bit not cleared by read");
	a_mask_rsv: assert property (mask_r[15:11] == 5'h00)
		else $error("reserved bits not zero");
endmodule

// ---- sim/mgmt_host.sv ----
/*
 * Management station model: clocks frames onto the serial management link.
 * Assumes clk_in is the system clock and the data pin has a pull-up.
 */
`timescale 1ns/100ps
module mgmt_host (
	// System clock
	input  wire logic clk_in,
	// Device side of the data pin
	input  wire logic dev_d_in,
	input  wire logic dev_oe_in,
	// Resolved pins
	output logic      mdc_out,
	output logic      mdio_out
);
	logic drv_r;
	logic d_r;

	// Released pin floats to the pull-up level
	assign mdio_out = dev_oe_in ? dev_d_in : (drv_r ? d_r : 1'b1);

	initial begin
		mdc_out = 1'b0;
		drv_r = 1'b0;
		d_r = 1'b1;
	end

	// Seven system clocks per bit; data moves only while the clock is low
	task automatic clk_bit(input logic drv, input logic b, output logic smp);
		@(negedge clk_in);
		mdc_out = 1'b0;
		drv_r = drv;
		d_r = b;
		repeat (3) @(negedge clk_in);
		smp = mdio_out;
		mdc_out = 1'b1;
		repeat (3) @(negedge clk_in);
	endtask

	// Clock stands still low between frames
	task automatic stop();
		@(negedge clk_in);
		mdc_out = 1'b0;
		drv_r = 1'b0;
	endtask

	task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] ph,
		input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] hdr;
		logic        smp;
		logic        rdf;
		hdr = {2'b01, op, ph, rg, 2'b10, wd};
		rdf = (op == 2'b10);
		repeat (pre) clk_bit(1'b1, 1'b1, smp);
		for (int i = 31; i >= 0; i--) begin
			clk_bit(!(rdf && i < 18), hdr[i], smp);
			if (i < 16) rd[i] = smp;
		end
		stop();
	endtask

	task automatic bits(input logic [1:0] v);
		logic smp;
		clk_bit(1'b1, v[1], smp);
		clk_bit(1'b1, v[0], smp);
		stop();
	endtask
endmodule

// ---- sim/phy_event_and_status_regs_tb.sv ----
/*
 * Self-checking bench for the event latch and link state report registers.
 * Assumes the management host model and address 5'h03 for this device.
 */
`timescale 1ns/100ps
`include "phy_evs_cfg.svh"
module phy_event_and_status_regs_tb;
	import phy_evs_pkg::*;
	logic         clk_in;
	logic         sys_rst_in;
	logic         mdc;
	logic         mdio;
	logic         dev_d;
	logic         dev_oe;
	logic         skip;
	logic         tdr;
	logic         srst;
	logic         spd;
	logic         irq_n;
	logic         drop;
	logic         sync;
	live_status_t live;
	ext_event_t   ev;
	logic [15:0]  seed_r;
	logic [15:0]  rdv;
	logic [15:0]  mask_m;
	logic [15:0]  evt_m;
	int           err_total = 0;
	int           check_count = 0;
	int           cyc = 0;
	int           pre_n = 32;

	phy_event_and_status_regs dut (
		.clk_in                 (clk_in),
		.sys_rst_in             (sys_rst_in),
		.mdc_in                 (mdc),
		.mdio_in                (mdio),
		.mdio_out               (dev_d),
		.mdio_oe_out            (dev_oe),
		.phy_addr_in            (5'h03),
		.frame_preamble_skip_in (skip),
		.tdr_mode_in            (tdr),
		.soft_reset_in          (srst),
		.soft_power_down_in     (spd),
		.live_in                (live),
		.events_in              (ev),
		.mgmt_irq_out_n         (irq_n),
		.link_drop_out          (drop),
		.in_sync_out            (sync)
	);

	mgmt_host host (
		.clk_in    (clk_in),
		.dev_d_in  (dev_d),
		.dev_oe_in (dev_oe),
		.mdc_out   (mdc),
		.mdio_out  (mdio)
	);

	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// Master/slave fault wins when both are raised
	function automatic logic [15:0] sts_exp();
		logic lk;
		lk = live.link_up & ~(srst | spd);
		return {tdr & ~lk, live[14], live[13] & ~live[14], live[12:7], lk, live[5:0]};
	endfunction

	function automatic logic pend();
		return |(evt_m[10:1] & mask_m[10:1]);
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic rd(input logic [4:0] ph, input logic [4:0] rg, output logic [15:0] d);
		host.frame(pre_n, `EVS_OP_READ, ph, rg, 16'h0000, d);
	endtask

	task automatic wr(input logic [4:0] rg, input logic [15:0] d);
		logic [15:0] x;
		host.frame(pre_n, `EVS_OP_WRITE, 5'h03, rg, d, x);
	endtask

	// Sources are idle at the read, so every latch is cleared afterwards
	task automatic rd_evt();
		rd(5'h03, `EVS_REG_EVT, rdv);
		chk(rdv, {5'h00, evt_m[10:1], pend()}, "event reg");
		evt_m = 16'h0000;
	endtask

	task automatic pulse(input int j);
		@(negedge clk_in);
		ev = ext_event_t'(9'h001 << j);
		evt_m[(j == 8) ? 10 : j + 1] = 1'b1;
		@(negedge clk_in);
		ev = '0;
	endtask

	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			test_done();
		end
	end

	initial begin
		sys_rst_in = 1'b1;
		skip = 1'b0;
		tdr = 1'b0;
		srst = 1'b0;
		spd = 1'b0;
		live = live_status_t'(15'h0700);
		ev = '0;
		seed_r = 16'h0EB4;
		mask_m = 16'h0000;
		evt_m = 16'h0000;
		repeat (8) @(negedge clk_in);
		chk({13'h0000, irq_n, sync, drop}, 16'h0006, "reset pins");
		sys_rst_in = 1'b0;
		rd(5'h03, `EVS_REG_STS, rdv);
		chk(rdv, `EVS_STS_RST, "status reset");
		rd_evt();
		rd(5'h03, `EVS_REG_MASK, rdv);
		chk(rdv, 16'h0000, "mask reset");
		rd(5'h03, 5'h05, rdv);
		chk(rdv, 16'h0000, "unmapped");
		rd(5'h04, `EVS_REG_EVT, rdv);
		chk(rdv, 16'hFFFF, "other address");
		$display("test reset done");

		for (int i = 0; i < 8; i++) begin
			seed_r = lfsr(seed_r);
			@(negedge clk_in);
			live = live_status_t'(seed_r[14:0]);
			tdr = seed_r[15];
			srst = seed_r[3] & seed_r[5];
			spd = seed_r[7] & seed_r[9];
			if (i == 0) begin
				live[14:13] = 2'b11;
				tdr = 1'b1;
				srst = 1'b1;
			end
			repeat (4) @(negedge clk_in);
			rd(5'h03, `EVS_REG_STS, rdv);
			chk(rdv, sts_exp(), "status");
			chk({15'h0000, drop}, {15'h0000, srst | spd}, "link drop");
		end
		srst = 1'b0;
		spd = 1'b0;
		$display("test status done");

		for (int k = 0; k < 3; k++) begin
			seed_r = lfsr(seed_r);
			if (k == 0) seed_r = 16'hFFFF;
			wr(`EVS_REG_MASK, seed_r);
			mask_m = seed_r & 16'h07FF;
			rd(5'h03, `EVS_REG_MASK, rdv);
			chk(rdv, mask_m, "mask");
			wr(`EVS_REG_EVT, 16'hFFFF);
			for (int j = 0; j < 9; j++) begin
				pulse(j);
				repeat (4) @(negedge clk_in);
				chk({15'h0000, irq_n}, {15'h0000, ~(mask_m[0] & pend())}, "irq pin");
				if (j % 3 != 2) rd_evt();
			end
			rd_evt();
		end
		$display("test events done");

		// Once synchronised, frames need no preamble in skip mode
		skip = 1'b1;
		pre_n = 0;
		rd(5'h03, `EVS_REG_STS, rdv);
		chk(rdv, sts_exp(), "no preamble");
		host.bits(2'b00);
		evt_m[9] = 1'b1;
		repeat (4) @(negedge clk_in);
		chk({15'h0000, sync}, 16'h0000, "sync lost");
		rd(5'h03, `EVS_REG_STS, rdv);
		chk(rdv, 16'hFFFF, "hunting");
		pre_n = 32;
		rd_evt();
		chk({15'h0000, sync}, 16'h0001, "resync");
		$display("test sync done");
		test_done();
	end
endmodule
